// >>> design/pst_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "pst_consts.vh"
module pst_regs #(
    parameter AW = 8,
    parameter DW = 8
) (
    // Clock, reset and chip enable
    input wire core_clk_i,
    input wire reset_i,
    input wire chip_en_i,
    // Host register port
    input wire wr_i,
    input wire rd_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o,
    output reg rvalid_o,
    // Transmit side
    input wire tx_pulse_start_i,
    output reg tx_mod_o,
    // Receive slot timing
    input wire slot_start_i,
    input wire resp_start_i,
    output reg no_resp_irq_o,
    output reg no_resp_flag_o,
    input wire no_resp_flag_clr_i,
    // Decoded configuration
    output reg rx_crc_check_o,
    output reg raw_mode1_o,
    output reg double_sub_o,
    output reg high_rate_o,
    output reg code_256_o,
    output reg proto_valid_o
);
    // Cycle counts at the 10 MHz core clock; the pulse rounds up, the timeout step rounds down
    localparam integer CLK_PS = `PST_CLK_PS;
    localparam integer PROTO_PULSE_CYC = (`PST_PROTO_PULSE_PS + CLK_PS - 1) / CLK_PS;
    localparam integer NORESP_STEP_CYC = `PST_NORESP_STEP_PS / CLK_PS;
    localparam integer STEP_CNT_W = 16;

    reg [7:0] proto;
    reg [7:0] pulse_len;
    reg [7:0] noresp;
    reg [STEP_CNT_W-1:0] step_cnt;
    reg carrier_tick;
    reg step_tick;
    wire proto_wr = wr_i && (addr_i == `PST_ADDR_PROTO);
    wire [7:0] next_noresp_preset;
    wire pulse_busy;
    wire tmo_busy;
    wire tmo_done;
    wire [STEP_CNT_W-1:0] pulse_load;

    assign next_noresp_preset = wdata_i[`PST_BIT_HIRATE] ? `PST_NORESP_HI : `PST_NORESP_LO;

    // Register file; chip enable low holds the defaults like reset
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            proto <= `PST_RST_PROTO;
            pulse_len <= `PST_RST_PULSE;
            noresp <= `PST_RST_NORESP;
        end else if (!chip_en_i) begin
            proto <= `PST_RST_PROTO;
            pulse_len <= `PST_RST_PULSE;
            noresp <= `PST_RST_NORESP;
        end else if (proto_wr) begin
            proto <= wdata_i;
            pulse_len <= `PST_RST_PULSE;
            noresp <= next_noresp_preset;
        end else if (wr_i && addr_i == `PST_ADDR_PULSE) begin
            pulse_len <= wdata_i;
        end else if (wr_i && addr_i == `PST_ADDR_NORESP) begin
            noresp <= wdata_i;
        end
    end

    // Reads return one cycle later and hold until the next read; unmapped addresses read zero
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                case (addr_i)
                    `PST_ADDR_PROTO: rdata_o <= proto;
                    `PST_ADDR_PULSE: rdata_o <= pulse_len;
                    `PST_ADDR_NORESP: rdata_o <= noresp;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Decoded outputs, registered
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_crc_check_o <= 1'b1;
            raw_mode1_o <= 1'b0;
            double_sub_o <= 1'b0;
            high_rate_o <= 1'b1;
            code_256_o <= 1'b0;
            proto_valid_o <= 1'b1;
        end else begin
            rx_crc_check_o <= ~proto[`PST_BIT_NOCRC];
            raw_mode1_o <= proto[`PST_BIT_RAWTYPE];
            double_sub_o <= proto[`PST_BIT_DOUBLE];
            high_rate_o <= proto[`PST_BIT_HIRATE];
            code_256_o <= proto[`PST_BIT_C256];
            // Reserved bit 5 or upper code bits flag an unsupported setting
            proto_valid_o <= ~proto[`PST_BIT_RESV] & ~proto[`PST_CODE_HI] & ~proto[`PST_CODE_LO];
        end
    end

    // The core clock is slower than the carrier, so carrier steps are converted
    // to whole core cycles in the pulse load and the pulse counts every cycle.
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            carrier_tick <= 1'b0;
            step_cnt <= {STEP_CNT_W{1'b0}};
            step_tick <= 1'b0;
        end else begin
            carrier_tick <= 1'b1;
            if (step_cnt == NORESP_STEP_CYC[STEP_CNT_W-1:0] - 16'h0001 || slot_start_i) begin
                step_cnt <= {STEP_CNT_W{1'b0}};
                step_tick <= ~slot_start_i;
            end else begin
                step_cnt <= step_cnt + 16'h0001;
                step_tick <= 1'b0;
            end
        end
    end

    // N carrier steps rounded up to whole core cycles; 32 bits avoid overflow at N = 255
    wire [31:0] pulse_len_ps = pulse_len * `PST_CARRIER_PS;
    wire [31:0] pulse_len_cyc = (pulse_len_ps + CLK_PS - 1) / CLK_PS;
    wire [STEP_CNT_W-1:0] pulse_ps_cyc = pulse_len_cyc[STEP_CNT_W-1:0];
    assign pulse_load = (pulse_len == `PST_RST_PULSE)
        ? PROTO_PULSE_CYC[STEP_CNT_W-1:0]
        : pulse_ps_cyc;

    pst_down_counter #(
        .WIDTH(STEP_CNT_W)
    ) u_pulse (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .start_i(tx_pulse_start_i),
        .stop_i(1'b0),
        .tick_i(carrier_tick),
        // The start cycle is the first pulse cycle, so one less is counted
        .load_i(pulse_load - {{(STEP_CNT_W-1){1'b0}}, 1'b1}),
        .busy_o(pulse_busy),
        .done_o()
    );

    pst_down_counter #(
        .WIDTH(STEP_CNT_W)
    ) u_noresp (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .start_i(slot_start_i),
        .stop_i(resp_start_i),
        .tick_i(step_tick),
        .load_i({8'h00, noresp}),
        .busy_o(tmo_busy),
        .done_o(tmo_done)
    );

    // Modulation output and no-response event; set wins over clear
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_mod_o <= 1'b0;
            no_resp_irq_o <= 1'b0;
            no_resp_flag_o <= 1'b0;
        end else begin
            tx_mod_o <= tx_pulse_start_i | pulse_busy;
            no_resp_irq_o <= tmo_done & ~resp_start_i;
            if (tmo_done && !resp_start_i) begin
                no_resp_flag_o <= 1'b1;
            end else if (no_resp_flag_clr_i) begin
                no_resp_flag_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/pst_consts.vh
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH
// Register addresses
`define PST_ADDR_PROTO 8'h01
`define PST_ADDR_PULSE 8'h06
`define PST_ADDR_NORESP 8'h07
// Reset values
`define PST_RST_PROTO 8'h02
`define PST_RST_PULSE 8'h00
`define PST_RST_NORESP 8'h0e
// Protocol register fields
`define PST_BIT_NOCRC 7
`define PST_BIT_RAWTYPE 6
`define PST_BIT_RESV 5
`define PST_BIT_DOUBLE 2
`define PST_BIT_HIRATE 1
`define PST_BIT_C256 0
`define PST_CODE_HI 4
`define PST_CODE_LO 3
// Timing figures, in picoseconds
`define PST_CARRIER_PS 73746
`define PST_PROTO_PULSE_PS 9440000
`define PST_NORESP_STEP_PS 37760000
`define PST_CLK_PS 100000
// Timeout presets: 755 us and 1812 us in 37.76 us steps
`define PST_NORESP_HI 8'h14
`define PST_NORESP_LO 8'h30
`endif

// >>> design/pst_down_counter.v
`timescale 1ns/100ps
`default_nettype none
// Down counter that counts on an enable pulse and flags expiry once.
module pst_down_counter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // Control
    input wire start_i,
    input wire stop_i,
    input wire tick_i,
    input wire [WIDTH-1:0] load_i,
    // Status
    output reg busy_o,
    output reg done_o
);
    reg [WIDTH-1:0] count;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count <= {WIDTH{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count <= load_i;
                busy_o <= (load_i != {WIDTH{1'b0}});
                done_o <= (load_i == {WIDTH{1'b0}});
            end else if (stop_i) begin
                busy_o <= 1'b0;
            end else if (busy_o && tick_i) begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/pst_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pst_regs_properties (
    // Watched ports
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic chip_en_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rvalid_o,
    input wire logic tx_pulse_start_i,
    input wire logic tx_mod_o,
    input wire logic slot_start_i,
    input wire logic no_resp_irq_o,
    input wire logic no_resp_flag_o,
    input wire logic rx_crc_check_o,
    input wire logic high_rate_o,
    input wire logic proto_valid_o
);
    wire pw = wr_i && chip_en_i && addr_i == 8'h01;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    chk_rd_answer: assert property (rd_i |=> rvalid_o) else $error("read not answered");
    chk_rvalid_cause: assert property (rvalid_o |-> $past(rd_i)) else $error("read answer without read");
    chk_crc_decode:
        assert property (pw ##1 chip_en_i |=> rx_crc_check_o == !$past(wdata_i[7], 2)) else $error("crc decode");
    chk_rate_decode:
        assert property (pw ##1 chip_en_i |=> high_rate_o == $past(wdata_i[1], 2)) else $error("rate decode");
    chk_valid_decode:
        assert property (pw ##1 chip_en_i |=> proto_valid_o == !(|$past(wdata_i[5:3], 2))) else $error("code check");
    chk_irq_pulse: assert property (no_resp_irq_o |=> !no_resp_irq_o) else $error("irq not one cycle");
    chk_irq_flag: assert property (no_resp_irq_o |-> ##[0:1] no_resp_flag_o) else $error("flag not set");
    chk_irq_wait: assert property (slot_start_i |=> !no_resp_irq_o [*8]) else $error("timeout too early");
    chk_en_default:
        assert property (!chip_en_i [*2] |=> high_rate_o && rx_crc_check_o && proto_valid_o) else $error("enable reset");
    chk_mod_cause: assert property ($rose(tx_mod_o) |-> $past(tx_pulse_start_i)) else $error("pulse unprompted");
endmodule
bind pst_regs pst_regs_properties i_pst_regs_properties (.core_clk_i, .reset_i, .chip_en_i, .wr_i, .rd_i,
    .addr_i, .wdata_i, .rvalid_o, .tx_pulse_start_i, .tx_mod_o, .slot_start_i, .no_resp_irq_o,
    .no_resp_flag_o, .rx_crc_check_o, .high_rate_o, .proto_valid_o);
`default_nettype wire

// >>> sim/pst_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pst_host_model (
    // Clock and register port answers
    input wire logic core_clk_i,
    input wire logic rvalid_o,
    input wire logic [7:0] rdata_o,
    // Register port requests
    output logic wr_i,
    output logic rd_i,
    output logic [7:0] addr_i,
    output logic [7:0] wdata_i
);
    initial begin
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= (a == 8'h01) ? (d & 8'hdf) : d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    // No answer yields unknown data so the caller's compare fails
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = (rvalid_o === 1'b1) ? rdata_o : 8'hxx;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk_i, reset_i, chip_en_i, wr_i, rd_i, rvalid_o, tx_pulse_start_i, tx_mod_o, slot_start_i;
    logic resp_start_i, no_resp_irq_o, no_resp_flag_o, no_resp_flag_clr_i, rx_crc_check_o, raw_mode1_o;
    logic double_sub_o, high_rate_o, code_256_o, proto_valid_o, seen;
    logic [7:0] addr_i, wdata_i, rdata_o, v;
    int error_cnt, comparisons, i;
    pst_regs i_pst_regs (.core_clk_i, .reset_i, .chip_en_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
        .rvalid_o, .tx_pulse_start_i, .tx_mod_o, .slot_start_i, .resp_start_i, .no_resp_irq_o, .no_resp_flag_o,
        .no_resp_flag_clr_i, .rx_crc_check_o, .raw_mode1_o, .double_sub_o, .high_rate_o, .code_256_o,
        .proto_valid_o);
    pst_host_model i_pst_host_model (.core_clk_i, .rvalid_o, .rdata_o, .wr_i, .rd_i, .addr_i, .wdata_i);
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rc(input logic [7:0] a, input logic [7:0] exp);
        i_pst_host_model.rd(a, v);
        cmp(v, exp);
    endtask
    task pulse(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        @(posedge core_clk_i);
        tx_pulse_start_i <= 1'b1;
        @(posedge core_clk_i);
        tx_pulse_start_i <= 1'b0;
        repeat (120) begin
            @(negedge core_clk_i);
            if (tx_mod_o === 1'b1)
                n = n + 1;
        end
        cmp(n, exp);
    endtask
    task slot;
        @(posedge core_clk_i);
        slot_start_i <= 1'b1;
        @(posedge core_clk_i);
        slot_start_i <= 1'b0;
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        reset_i = 1'b1;
        chip_en_i = 1'b1;
        tx_pulse_start_i = 1'b0;
        slot_start_i = 1'b0;
        resp_start_i = 1'b0;
        no_resp_flag_clr_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rc(8'h01, 8'h02);
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h0e);
        cmp({5'd0, high_rate_o, rx_crc_check_o, proto_valid_o}, 8'h07);
        $display("test reset done");
        i_pst_host_model.wr(8'h06, 8'h05);
        i_pst_host_model.wr(8'h07, 8'h03);
        rc(8'h06, 8'h05);
        i_pst_host_model.wr(8'h01, 8'h85);
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h30);
        cmp({4'd0, rx_crc_check_o, double_sub_o, high_rate_o, code_256_o}, 8'h05);
        i_pst_host_model.wr(8'h01, 8'h42);
        rc(8'h07, 8'h14);
        cmp({4'd0, raw_mode1_o, double_sub_o, high_rate_o, code_256_o}, 8'h0a);
        rc(8'h05, 8'h00);
        $display("test protocol done");
        i_pst_host_model.wr(8'h06, 8'h0a);
        pulse(8'd8);
        i_pst_host_model.wr(8'h01, 8'h02);
        pulse(8'd95);
        $display("test pulse done");
        i_pst_host_model.wr(8'h07, 8'h01);
        slot();
        for (i = 0; i < 1000 && no_resp_irq_o !== 1'b1; i++)
            @(negedge core_clk_i);
        cmp({7'd0, i >= 376 && i <= 381}, 8'h01);
        cmp({7'd0, no_resp_flag_o}, 8'h01);
        @(posedge core_clk_i);
        no_resp_flag_clr_i <= 1'b1;
        @(posedge core_clk_i);
        no_resp_flag_clr_i <= 1'b0;
        @(posedge core_clk_i);
        cmp({7'd0, no_resp_flag_o}, 8'h00);
        // A response that begins in time must suppress the timeout
        slot();
        repeat (20) @(posedge core_clk_i);
        resp_start_i <= 1'b1;
        @(posedge core_clk_i);
        resp_start_i <= 1'b0;
        seen = 1'b0;
        repeat (500) begin
            @(negedge core_clk_i);
            if (no_resp_irq_o === 1'b1)
                seen = 1'b1;
        end
        cmp({7'd0, seen}, 8'h00);
        $display("test timeout done");
        i_pst_host_model.wr(8'h01, 8'h03);
        i_pst_host_model.wr(8'h06, 8'h33);
        @(posedge core_clk_i);
        chip_en_i <= 1'b0;
        i_pst_host_model.wr(8'h06, 8'h44);
        @(posedge core_clk_i);
        chip_en_i <= 1'b1;
        rc(8'h06, 8'h00);
        rc(8'h01, 8'h02);
        rc(8'h07, 8'h0e);
        $display("test enable done");
        summarize();
    end
endmodule
`default_nettype wire
